// >>> src/scan_bus_master.sv
// scan bus master pin logic: host port, target port, reset sequencing
`include "scan_bus_master_cfg.svh"
module scan_bus_master
   import scan_bus_master_pkg::*;
#(
   parameter int unsigned SWRST_CYC = `SWRST_CYC_DEF
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [4:0]  host_reg_addr_i,
   input  wire logic [15:0] host_data_bus_i,
   output logic [15:0]      host_data_bus_o,
   output logic             host_data_bus_oe_o,
   input  wire logic        rd_n_i,
   input  wire logic        wr_n_i,
   output logic             rdy_n_o,
   output logic             int_n_o,
   input  wire logic        test_clock_in_i,
   input  wire logic [1:0]  scan_return_in_i,
   input  wire logic        target_outputs_off_n_i,
   output logic             test_clock_fwd_o,
   output logic             test_clock_fwd_oe_o,
   output logic             scan_data_out_o,
   output logic             scan_data_out_oe_o,
   output logic [1:0]       mode_select_out_o,
   output logic             mode_select_out_oe_o,
   input  wire logic [3:0]  shared_select_or_event_pin_i,
   output logic [3:0]       shared_select_or_event_pin_o,
   output logic [3:0]       shared_select_or_event_pin_oe_o
);

   state_t      q;
   state_t      n;
   pin_in_t     pins_in;
   pin_in_t     diff;
   logic        run;
   logic        tck_rise;
   logic        tck_fall;
   logic        smp;
   logic        wr_rise;
   logic        rd_rise;
   logic        ret_sel;
   logic        oe_ok;
   logic [3:0]  is_evt;
   fwd_mode_t   fwd_mode;

   // pin inputs gathered for the synchroniser
   assign pins_in = '{tck: test_clock_in_i, rd_n: rd_n_i, wr_n: wr_n_i,
                      addr: host_reg_addr_i, data: host_data_bus_i,
                      ret: scan_return_in_i,
                      evt: shared_select_or_event_pin_i,
                      off_n: target_outputs_off_n_i};
   assign diff = q.s2 ^ q.s3;

   // edges of the filtered test clock and strobes
   assign run      = (q.phase == PH_RUN);
   assign tck_rise = q.f.tck & ~q.tck_prev;
   assign tck_fall = ~q.f.tck & q.tck_prev;
   assign smp      = q.regs.ctrl[`CTRL_SMP_FALL] ? tck_fall : tck_rise;
   assign wr_rise  = q.f.wr_n & ~q.wr_prev;
   assign rd_rise  = q.f.rd_n & ~q.rd_prev;
   assign ret_sel  = q.f.ret[q.regs.ctrl[`CTRL_RET_SEL]];
   assign is_evt   = q.regs.ctrl[`CTRL_EVT_LSB +: 4];
   assign fwd_mode = fwd_mode_t'(q.regs.ctrl[`CTRL_FWD_LSB +: 2]);
   assign oe_ok    = q.f.off_n & run;

   // next-state logic
   always_comb begin
      n = q;
      n.s1 = pins_in;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // a bit changes only once the second and third stages agree
      n.f = pin_in_t'((q.s3 & ~diff) | (q.f & diff));
      n.tck_prev = q.f.tck;
      n.rd_prev  = q.f.rd_n;
      n.wr_prev  = q.f.wr_n;
      n.data_oe  = ~q.f.rd_n & run;
      case (q.phase)
         PH_HWRST: begin
            n.phase     = PH_SWRST;
            n.swrst_cnt = 8'h00;
         end
         PH_SWRST: begin
            n.regs = '0;
            n.recover = 2'h0;
            if (tck_rise) begin
               if (q.swrst_cnt == 8'(SWRST_CYC - 1)) begin
                  n.phase = PH_RUN;
               end else begin
                  n.swrst_cnt = q.swrst_cnt + 8'h01;
               end
            end
         end
         PH_RUN: begin
            if (q.recover != 2'h0) begin
               n.recover = q.recover - 2'h1;
            end
            // follow address and data while the write strobe is low
            if (!q.f.wr_n) begin
               n.wr_addr = q.f.addr;
               n.wr_data = q.f.data;
            end
            // read mux, returned on the bus during the strobe
            case (q.f.addr)
               `REG_CTRL: n.rd_data = q.regs.ctrl;
               `REG_WBUF: n.rd_data = q.regs.wbuf;
               `REG_RBUF: n.rd_data = q.regs.rbuf;
               `REG_STAT: n.rd_data = {12'h000, q.regs.evt_stat};
               `REG_PINS: n.rd_data = q.regs.pins;
               `REG_CMD:  n.rd_data = {6'h00, q.regs.cap_cnt,
                                       q.regs.shift_cnt};
               default: begin
                  if (q.f.addr < `NUM_REGS) begin
                     n.rd_data = q.regs.scratch[q.f.addr - `SCRATCH_BASE];
                  end else begin
                     n.rd_data = 16'h0000;
                  end
               end
            endcase
            if (rd_rise) begin
               n.recover = `RECOVER_CYC;
            end
            // serial output shifts on the test clock fall
            if (tck_fall) begin
               if (q.regs.shift_cnt != 5'h00) begin
                  n.sdo = q.regs.wbuf[0];
                  n.regs.wbuf = {1'b0, q.regs.wbuf[15:1]};
                  n.regs.shift_cnt = q.regs.shift_cnt - 5'h01;
               end
               n.ms = q.regs.pins[`PINS_MS_LSB +: 2];
               for (int i = 0; i < 4; i++) begin
                  if (is_evt[i]) begin
                     n.sh[i]    = q.regs.pins[`PINS_EVO_LSB + i];
                     n.sh_oe[i] = q.regs.pins[`PINS_EVE_LSB + i];
                  end else begin
                     n.sh[i]    = q.regs.pins[`PINS_SH_LSB + i];
                     n.sh_oe[i] = 1'b1;
                  end
               end
               n.sdo_oe = 1'b1;
               n.ms_oe  = 1'b1;
            end
            // return data collected from the selected input
            if (smp) begin
               n.evt_prev = q.f.evt;
               if (q.regs.cap_cnt != 5'h00) begin
                  n.regs.rbuf = {ret_sel, q.regs.rbuf[15:1]};
                  n.regs.cap_cnt = q.regs.cap_cnt - 5'h01;
               end
            end
            // host write decode
            if (wr_rise) begin
               n.recover = `RECOVER_CYC;
               case (q.wr_addr)
                  `REG_CTRL: n.regs.ctrl = q.wr_data;
                  `REG_WBUF: n.regs.wbuf = q.wr_data;
                  `REG_STAT: n.regs.evt_stat = q.regs.evt_stat &
                                               ~q.wr_data[3:0];
                  `REG_PINS: n.regs.pins = q.wr_data;
                  `REG_CMD: begin
                     if (q.wr_data[4:0] > `SHIFT_MAX) begin
                        n.regs.shift_cnt = `SHIFT_MAX;
                        n.regs.cap_cnt   = `SHIFT_MAX;
                     end else begin
                        n.regs.shift_cnt = q.wr_data[4:0];
                        n.regs.cap_cnt   = q.wr_data[4:0];
                     end
                  end
                  default: begin
                     if (q.wr_addr >= `SCRATCH_BASE &&
                         q.wr_addr < `NUM_REGS) begin
                        n.regs.scratch[q.wr_addr - `SCRATCH_BASE] =
                           q.wr_data;
                     end
                  end
               endcase
            end
            // received events are sticky; a set beats a clear
            if (smp) begin
               n.regs.evt_stat = n.regs.evt_stat |
                                 (q.evt_prev & ~q.f.evt & is_evt);
            end
         end
         default: n.phase = PH_HWRST;
      endcase
      // forwarded clock takes the same one-cycle path as the data outputs
      case (fwd_mode)
         FWD_ZERO:   n.fwd = 1'b0;
         FWD_ONE:    n.fwd = 1'b1;
         FWD_FOLLOW: n.fwd = q.f.tck;
         default:    n.fwd = 1'b0;
      endcase
      n.fwd_oe = (fwd_mode != FWD_OFF);
      n.int_n  = ~(|n.regs.evt_stat);
   end

   // state register with synchronous reset
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         q          <= '0;
         q.int_n    <= 1'b1;
         q.rd_prev  <= 1'b1;
         q.wr_prev  <= 1'b1;
         q.f.rd_n   <= 1'b1;
         q.f.wr_n   <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // outputs; target output enables are cut by test-off once it has passed the synchroniser
   assign host_data_bus_o     = q.rd_data;
   assign host_data_bus_oe_o  = q.data_oe & ~q.f.rd_n;
   assign rdy_n_o             = ~run | (q.recover != 2'h0) |
                                (q.regs.shift_cnt != 5'h00) |
                                (q.regs.cap_cnt != 5'h00);
   assign int_n_o             = q.int_n;
   assign test_clock_fwd_o    = q.fwd;
   assign test_clock_fwd_oe_o = q.fwd_oe & oe_ok;
   assign scan_data_out_o     = q.sdo;
   assign scan_data_out_oe_o  = q.sdo_oe & oe_ok;
   assign mode_select_out_o   = q.ms;
   assign mode_select_out_oe_o = q.ms_oe & oe_ok;
   assign shared_select_or_event_pin_o    = q.sh;
   assign shared_select_or_event_pin_oe_o = q.sh_oe & {4{oe_ok}};

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_data_oe_read;
      host_data_bus_oe_o |-> !q.f.rd_n && run;
   endproperty
   a_data_oe_read: assert property (p_data_oe_read)
      else $error("data bus driven outside read");

   property p_int_low;
      (|q.regs.evt_stat) |-> !int_n_o;
   endproperty
   a_int_low: assert property (p_int_low)
      else $error("interrupt not low with pending event");

   property p_rdy_write;
      wr_rise && run |=> rdy_n_o [*3];
   endproperty
   a_rdy_write: assert property (p_rdy_write)
      else $error("ready asserted during write recovery");

   property p_rdy_swrst;
      q.phase != PH_RUN |-> rdy_n_o;
   endproperty
   a_rdy_swrst: assert property (p_rdy_swrst)
      else $error("ready asserted during reset");

   property p_sdo_fall;
      $changed(scan_data_out_o) |-> $past(tck_fall);
   endproperty
   a_sdo_fall: assert property (p_sdo_fall)
      else $error("serial output changed off a falling edge");

   property p_fwd_follow;
      fwd_mode == FWD_FOLLOW |=> test_clock_fwd_o == $past(q.f.tck);
   endproperty
   a_fwd_follow: assert property (p_fwd_follow)
      else $error("forwarded clock not aligned to data path");

   property p_fwd_zero;
      fwd_mode == FWD_ZERO |=> !test_clock_fwd_o && q.fwd_oe;
   endproperty
   a_fwd_zero: assert property (p_fwd_zero)
      else $error("forwarded clock not held at zero");

   property p_off;
      !q.f.off_n |-> !test_clock_fwd_oe_o && !scan_data_out_oe_o &&
                     !mode_select_out_oe_o &&
                     (shared_select_or_event_pin_oe_o == 4'h0);
   endproperty
   a_off: assert property (p_off)
      else $error("target output enabled during test-off");

   property p_capture;
      run && smp && q.regs.cap_cnt != 5'h00 && !wr_rise
         |=> q.regs.rbuf[15] == $past(ret_sel);
   endproperty
   a_capture: assert property (p_capture)
      else $error("read buffer missed selected return bit");

   property p_write_ctrl;
      run && wr_rise && q.wr_addr == `REG_CTRL
         |=> q.regs.ctrl == $past(q.wr_data);
   endproperty
   a_write_ctrl: assert property (p_write_ctrl)
      else $error("control write not taken at strobe rise");

   property p_swrst_len;
      $rose(run) |-> $past(tck_rise);
   endproperty
   a_swrst_len: assert property (p_swrst_len)
      else $error("software reset ended off a clock rise");

   property p_rdy_read;
      rd_rise && run |=> rdy_n_o [*3];
   endproperty
   a_rdy_read: assert property (p_rdy_read)
      else $error("ready asserted during read recovery");

   property p_sdo_lsb;
      run && tck_fall && q.regs.shift_cnt != 5'h00
         |=> scan_data_out_o == $past(q.regs.wbuf[0]);
   endproperty
   a_sdo_lsb: assert property (p_sdo_lsb)
      else $error("serial output not the next write buffer bit");

   property p_ms_fall;
      $changed(mode_select_out_o) |-> $past(tck_fall);
   endproperty
   a_ms_fall: assert property (p_ms_fall)
      else $error("mode select changed off a falling edge");

   property p_evt_set;
      run && smp && q.evt_prev[0] && !q.f.evt[0] && is_evt[0]
         |=> q.regs.evt_stat[0];
   endproperty
   a_evt_set: assert property (p_evt_set)
      else $error("event edge lost against a status clear");

   property p_cov_shift;
      run && q.regs.shift_cnt != 5'h00 ##1 q.regs.shift_cnt == 5'h00;
   endproperty
   c_shift: cover property (p_cov_shift);

   property p_cov_evt;
      $fell(int_n_o);
   endproperty
   c_evt: cover property (p_cov_evt);

   property p_cov_read;
      host_data_bus_oe_o ##1 !host_data_bus_oe_o;
   endproperty
   c_read: cover property (p_cov_read);

   property p_cov_fall_smp;
      run && q.regs.ctrl[`CTRL_SMP_FALL] && smp &&
         q.regs.cap_cnt != 5'h00;
   endproperty
   c_fall_smp: cover property (p_cov_fall_smp);

   property p_cov_off;
      run && $fell(q.f.off_n);
   endproperty
   c_off: cover property (p_cov_off);

endmodule

// >>> src/scan_bus_master_cfg.svh
// scan bus master constants: register indices, field positions and counts
// Overview of operation
// - host picks register with 5-bit address
// - registers exchanged over 16-bit two-way data bus
// - interrupt low until host finishes service
// - data bus driven only during read strobe
// - ready low when access can be accepted
// - ready high during read/write/command/reset recovery
// - logic runs on core clock; test clock input is synchronised
// - target outputs change on test clock fall
// - target inputs sampled on configured clock edge
// - forwarded clock: off, zero, one, follow
// - followed clock delayed like data outputs
// - two serial return inputs from targets
// - one serial data output to targets
// - two dedicated mode-select outputs
// - four shared pins: mode-select or event
// - event pins receive and transmit events
// - test-off low disables all target outputs
// - hardware reset starts when reset goes low
// - software reset runs fixed clock count after
// - address and data taken at write rise
// - selected return input collected into read buffer
// - twenty-four addressable registers
`ifndef SCAN_BUS_MASTER_CFG_SVH
`define SCAN_BUS_MASTER_CFG_SVH

`define ADDR_W        5
`define DATA_W        16
`define NUM_REGS      5'h18
`define REG_CTRL      5'h00
`define REG_WBUF      5'h01
`define REG_RBUF      5'h02
`define REG_STAT      5'h03
`define REG_PINS      5'h04
`define REG_CMD       5'h05
`define SCRATCH_BASE  5'h06
`define SCRATCH_N     18
`define CTRL_FWD_LSB  0
`define CTRL_SMP_FALL 2
`define CTRL_RET_SEL  3
`define CTRL_EVT_LSB  4
`define PINS_MS_LSB   0
`define PINS_SH_LSB   2
`define PINS_EVO_LSB  6
`define PINS_EVE_LSB  10
`define SHIFT_MAX     5'h10
`define RECOVER_CYC   2'h3
`define SWRST_CYC_DEF 8

`endif

// >>> src/scan_bus_master_pkg.sv
// scan bus master types: pin groups, modes and module state
`include "scan_bus_master_cfg.svh"
package scan_bus_master_pkg;

   typedef enum logic [1:0] {PH_HWRST, PH_SWRST, PH_RUN} phase_t;
   typedef enum logic [1:0] {FWD_OFF, FWD_ZERO, FWD_ONE, FWD_FOLLOW} fwd_mode_t;

   // every pin input that passes the synchroniser
   typedef struct packed {
      logic               tck;
      logic               rd_n;
      logic               wr_n;
      logic [4:0]         addr;
      logic [15:0]        data;
      logic [1:0]         ret;
      logic [3:0]         evt;
      logic               off_n;
   } pin_in_t;

   // host-visible registers
   typedef struct packed {
      logic [15:0]        ctrl;
      logic [15:0]        wbuf;
      logic [15:0]        rbuf;
      logic [3:0]         evt_stat;
      logic [15:0]        pins;
      logic [4:0]         shift_cnt;
      logic [4:0]         cap_cnt;
      logic [`SCRATCH_N-1:0][15:0] scratch;
   } host_regs_t;

   typedef struct packed {
      phase_t             phase;
      logic [7:0]         swrst_cnt;
      pin_in_t            s1;
      pin_in_t            s2;
      pin_in_t            s3;
      pin_in_t            f;
      logic               tck_prev;
      logic               rd_prev;
      logic               wr_prev;
      logic [3:0]         evt_prev;
      logic [4:0]         wr_addr;
      logic [15:0]        wr_data;
      logic [1:0]         recover;
      logic [15:0]        rd_data;
      logic               data_oe;
      logic               int_n;
      host_regs_t         regs;
      logic               fwd;
      logic               fwd_oe;
      logic               sdo;
      logic               sdo_oe;
      logic [1:0]         ms;
      logic               ms_oe;
      logic [3:0]         sh;
      logic [3:0]         sh_oe;
   } state_t;

endpackage

// >>> verification/scan_bus_master_test.sv
// self-checking bench for the scan bus master pin logic
`include "scan_bus_master_cfg.svh"
module scan_bus_master_test
   import scan_bus_master_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst_n, rd_n, wr_n, tck, off_n, hdrv;
   logic        dbus_oe, rdy_n, int_n, fwd, fwd_oe, sdo, sdo_oe, ms_oe;
   logic        s0, s1;
   logic [4:0]  addr;
   logic [15:0] hdata, dbus_o, dbus, v;
   logic [1:0]  ms, ret;
   logic [3:0]  sh_o, sh_oe, sh_w, evt_low;
   logic [7:0]  terr;
   int          fail_count, cmp_count;

   // released data bus floats high on the pull-ups
   assign dbus = dbus_oe ? dbus_o : (hdrv ? hdata : 16'hffff);

   scan_bus_master #(.SWRST_CYC(2)) uut (
      .core_clk_i(clk), .rst_n_i(rst_n), .host_reg_addr_i(addr),
      .host_data_bus_i(dbus), .host_data_bus_o(dbus_o),
      .host_data_bus_oe_o(dbus_oe), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .rdy_n_o(rdy_n), .int_n_o(int_n), .test_clock_in_i(tck),
      .scan_return_in_i(ret), .target_outputs_off_n_i(off_n),
      .test_clock_fwd_o(fwd), .test_clock_fwd_oe_o(fwd_oe),
      .scan_data_out_o(sdo), .scan_data_out_oe_o(sdo_oe),
      .mode_select_out_o(ms), .mode_select_out_oe_o(ms_oe),
      .shared_select_or_event_pin_i(sh_w),
      .shared_select_or_event_pin_o(sh_o),
      .shared_select_or_event_pin_oe_o(sh_oe));

   scan_target_model tgt (
      .tck_i(tck), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .ms_i(ms),
      .ms_oe_i(ms_oe), .sh_i(sh_o), .sh_oe_i(sh_oe),
      .evt_low_i(evt_low), .ret_o(ret), .sh_wire_o(sh_w),
      .err_cnt_o(terr));

   // core clock 8 ns, test clock 160 ns
   always #4 clk = ~clk;
   always #80 tck = ~tck;

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // host may only start a strobe once ready is low
   task automatic wait_rdy();
      int n;
      n = 0;
      while (rdy_n !== 1'b0 && n < 3000) begin
         step(1);
         n++;
      end
      if (n >= 3000) chk("ready wait", 16'h1, 16'h0);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      int n;
      wait_rdy();
      addr = a;
      hdata = d;
      hdrv = 1'b1;
      wr_n = 1'b0;
      step(5);
      wr_n = 1'b1;
      n = 0;
      while (rdy_n !== 1'b1 && n < 10) begin
         step(1);
         n++;
      end
      chk("ready after write", {15'h0, rdy_n}, 16'h1);
      hdrv = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      int n;
      wait_rdy();
      addr = a;
      rd_n = 1'b0;
      n = 0;
      while (dbus_oe !== 1'b1 && n < 10) begin
         step(1);
         n++;
      end
      step(2);
      d = dbus;
      rd_n = 1'b1;
      step(8);
      chk("bus released", {15'h0, dbus_oe}, 16'h0);
   endtask

   task automatic rdck(input string nm, input logic [4:0] a,
                       input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(nm, d, exp);
   endtask

   task automatic wrap_up();
      chk("target edge faults", {8'h0, terr}, 16'h0);
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // tests need under 5k core cycles; allow ten times that
   initial begin
      #400000;
      fail_count++;
      wrap_up();
   end

   initial begin
      clk = 1'b0;
      tck = 1'b0;
      rst_n = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      off_n = 1'b1;
      hdrv = 1'b0;
      addr = 5'h00;
      hdata = 16'h0000;
      evt_low = 4'h0;
      fail_count = 0;
      cmp_count = 0;
      step(3);
      chk("reset outputs", {12'h0, dbus_oe, fwd_oe, rdy_n, int_n},
          16'h3);
      rst_n = 1'b1;
      step(2);
      chk("ready in soft reset", {15'h0, rdy_n}, 16'h1);
      $display("test reset done");

      wr(5'h06, 16'h5a3c);
      wr(5'h17, 16'hc3a5);
      wr(5'h18, 16'h1234);
      wr(`REG_RBUF, 16'hbeef);
      rdck("scratch first", 5'h06, 16'h5a3c);
      rdck("scratch last", 5'h17, 16'hc3a5);
      rdck("unmapped", 5'h18, 16'h0000);
      rdck("read buffer", `REG_RBUF, 16'h0000);
      $display("test host access done");

      for (int m = 0; m < 3; m++) begin
         wr(`REG_CTRL, 16'(m));
         step(60);
         chk("fwd enable", {15'h0, fwd_oe}, 16'(m != 0));
         if (m != 0) chk("fwd level", {15'h0, fwd}, 16'(m - 1));
      end
      wr(`REG_CTRL, 16'h0003);
      s0 = 1'b0;
      s1 = 1'b0;
      repeat (60) begin
         step(1);
         if (fwd === 1'b0) s0 = 1'b1;
         if (fwd === 1'b1) s1 = 1'b1;
      end
      chk("fwd follows", {14'h0, s1, s0}, 16'h3);
      $display("test forwarded clock done");

      wr(`REG_PINS, 16'h0016);
      step(60);
      chk("dedicated select", {13'h0, ms_oe, ms}, 16'h6);
      chk("shared select", {8'h0, sh_oe, sh_o}, 16'hf5);
      off_n = 1'b0;
      step(6);
      chk("outputs off", {11'h0, fwd_oe, sdo_oe, ms_oe, |sh_oe, 1'b0},
          16'h0);
      off_n = 1'b1;
      step(60);
      chk("outputs back", {14'h0, sdo_oe, ms_oe}, 16'h3);
      $display("test pins done");

      wr(`REG_WBUF, 16'ha5c3);
      wr(`REG_CMD, 16'h0010);
      rdck("capture line 0", `REG_RBUF, 16'hffff);
      // line 1 loops the output back; the command is issued just after
      // a test clock rise so that a fall is the first edge to act
      for (int e = 0; e < 2; e++) begin
         wr(`REG_CTRL, e ? 16'h000f : 16'h000b);
         wr(`REG_WBUF, 16'ha5c3);
         wait_rdy();
         @(posedge tck);
         step(1);
         wr(`REG_CMD, 16'h0010);
         rd(`REG_RBUF, v);
         // sampling on the fall takes the stale bit first, one bit early
         chk("scan loopback", v, e ? 16'h4b87 : 16'ha5c3);
      end
      $display("test capture done");

      wr(`REG_CTRL, 16'h0033);
      wr(`REG_PINS, 16'h0880);
      step(60);
      chk("event drive", {14'h0, sh_oe[1], sh_o[1]}, 16'h3);
      chk("no interrupt", {15'h0, int_n}, 16'h1);
      evt_low = 4'h1;
      step(60);
      evt_low = 4'h0;
      step(40);
      chk("interrupt", {15'h0, int_n}, 16'h0);
      rdck("event status", `REG_STAT, 16'h0001);
      chk("interrupt held", {15'h0, int_n}, 16'h0);
      wr(`REG_STAT, 16'h0001);
      step(6);
      chk("interrupt cleared", {15'h0, int_n}, 16'h1);
      $display("test events done");
      wrap_up();
   end
endmodule

// >>> verification/scan_target_model.sv
// scan target model: serial return lines, event pulls, edge watch
module scan_target_model (
   input  wire logic       tck_i,
   input  wire logic       sdo_i,
   input  wire logic       sdo_oe_i,
   input  wire logic [1:0] ms_i,
   input  wire logic       ms_oe_i,
   input  wire logic [3:0] sh_i,
   input  wire logic [3:0] sh_oe_i,
   input  wire logic [3:0] evt_low_i,
   output logic [1:0]      ret_o,
   output logic [3:0]      sh_wire_o,
   output logic [7:0]      err_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       byp_r = 1'b1;
   logic [7:0] err_r = 8'h00;

   // line 0 idles high; line 1 is a one-bit bypass target that takes
   // the serial output on each test clock rise
   always @(posedge tck_i) begin
      byp_r <= sdo_i;
   end
   assign ret_o = {byp_r, 1'b1};
   assign err_cnt_o = err_r;

   // released shared pins sit high on the pull-up unless pulled low
   assign sh_wire_o = (sh_oe_i & sh_i) | (~sh_oe_i & ~evt_low_i);

   // an enabled output that moves while the test clock is high is a fault
   always @(sdo_i, ms_i, sh_i) begin
      if (tck_i === 1'b1 && (sdo_oe_i === 1'b1 || ms_oe_i === 1'b1 ||
          |sh_oe_i === 1'b1)) begin
         err_r <= err_r + 8'h01;
      end
   end
endmodule
